// >>> core/gate3_sel_pkg.sv
// Constants and types for the gate-three input selection stage
// Summary of operation
// - Bit 7 gates input d true into gate.
// - Bit 6 gates input d inverted into gate.
// - Bit 5 gates input c true into gate.
// - Bit 4 gates input c inverted into gate.
// - Bit 3 gates input b true into gate.
// - Bit 2 gates input b inverted into gate.
// - Bit 1 gates input a true into gate.
// - Bit 0 gates input a inverted into gate.
// - Selection bits read/write; only power-on reset loads them.
package gate3_sel_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Number of cell data inputs; each has two terms
    localparam int NUM_INPUTS = 4;

    // Offset of the selection register on the register port
    localparam logic [ADDR_W-1:0] SEL_OFFSET = 8'h00;

    // Value loaded by a power-on or brown-out reset
    localparam logic [DATA_W-1:0] SEL_POR_VALUE = 8'h00;

    // Read answer for an unmapped address
    localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 8'h00;

    // Field positions: true enable at 2i+1, inverted at 2i
    localparam int TRUE_OFS = 1;
    localparam int INV_OFS  = 0;

    // Selection register fields, bit 7 down to bit 0
    typedef struct packed {
        logic g3_in4_true_en;   // Input d true
        logic g3_in4_inv_en;    // Input d inverted
        logic g3_in3_true_en;   // Input c true
        logic g3_in3_inv_en;    // Input c inverted
        logic g3_in2_true_en;   // Input b true
        logic g3_in2_inv_en;    // Input b inverted
        logic g3_in1_true_en;   // Input a true
        logic g3_in1_inv_en;    // Input a inverted
    } gate3_input_select_t;

    // Selected cell data lines, d in the top bit
    typedef struct packed {
        logic cell_data_in_d;   // Fourth data line
        logic cell_data_in_c;   // Third data line
        logic cell_data_in_b;   // Second data line
        logic cell_data_in_a;   // First data line
    } cell_data_t;

endpackage

// >>> core/gate3_term_or.sv
// Combinational OR of the enabled true and inverted data terms
`timescale 1ns/1ps
`default_nettype none

module gate3_term_or #(
    parameter int NUM_INPUTS = gate3_sel_pkg::NUM_INPUTS
) (
    input  wire logic [2*NUM_INPUTS-1:0] i_sel,   // Term enables
    input  wire logic [NUM_INPUTS-1:0]   i_data,  // Data lines
    output logic                         o_gate   // OR of enabled terms
);

    // Per input, the true and inverted contributions
    logic [NUM_INPUTS-1:0] true_term;  // Enabled true terms
    logic [NUM_INPUTS-1:0] inv_term;   // Enabled inverted terms

    // One pair of terms for each data line
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : g_term
            // True form, enable at the odd bit
            assign true_term[g] =
                i_sel[2*g+gate3_sel_pkg::TRUE_OFS] & i_data[g];
            // Inverted form, enable at the even bit
            assign inv_term[g] =
                i_sel[2*g+gate3_sel_pkg::INV_OFS] & ~i_data[g];
        end
    endgenerate

    // No enabled term leaves the gate at zero
    assign o_gate = (|true_term) | (|inv_term);

endmodule // gate3_term_or

`default_nettype wire

// >>> core/gate3_input_stage.sv
// Gate-three selection register, its port, and registered gate output
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module gate3_input_stage (
    input  wire logic                            i_ref_clk,   // System clock
    input  wire logic                            i_srst,      // Other resets
    input  wire logic                            i_por,       // POR or BOR
    input  wire logic [gate3_sel_pkg::ADDR_W-1:0] i_addr,     // Reg address
    input  wire logic [gate3_sel_pkg::DATA_W-1:0] i_wdata,    // Write data
    input  wire logic                            i_wr,        // Write strobe
    input  wire logic                            i_rd,        // Read strobe
    input  wire gate3_sel_pkg::cell_data_t       i_cell_data, // Data lines
    output logic [gate3_sel_pkg::DATA_W-1:0]     o_rdata,     // Read data
    output logic                                 o_gate3,     // Gate output
    output var gate3_sel_pkg::gate3_input_select_t o_sel      // Live setting
);

    // Selection register and its next value
    gate3_sel_pkg::gate3_input_select_t sel;       // Stored enables
    gate3_sel_pkg::gate3_input_select_t next_sel;  // Value after edge

    // Read data register and its next value
    logic [gate3_sel_pkg::DATA_W-1:0] rdata;       // Registered answer
    logic [gate3_sel_pkg::DATA_W-1:0] next_rdata;  // Answer to latch

    // Gate output register and its next value
    logic gate_q;       // Registered gate
    logic next_gate;    // Combinational OR

    // Address decode for the one mapped register
    logic sel_hit;      // Address matches selection register

    assign sel_hit = (i_addr == gate3_sel_pkg::SEL_OFFSET);

    // Selection register next value
    always_comb begin
        next_sel = sel;
        if (i_por) begin
            // Power-on or brown-out loads a known pattern
            next_sel = gate3_sel_pkg::SEL_POR_VALUE;
        end else if (i_wr && sel_hit) begin
            // Software write; other resets leave it alone
            next_sel = i_wdata;
        end
    end

    // Register the selection; i_srst deliberately not used here
    // No reset term: only power-on or a write may change the setting
    always_ff @(posedge i_ref_clk) begin
        sel <= next_sel;
    end

    // Read answer, valid only the cycle after the strobe
    always_comb begin
        next_rdata = gate3_sel_pkg::UNMAPPED_VALUE;
        if (i_rd && sel_hit) begin
            // Readback of all eight bits
            next_rdata = sel;
        end
    end

    // Register the read answer
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata <= gate3_sel_pkg::UNMAPPED_VALUE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Per-term enables and OR into gate three
    gate3_term_or #(
        .NUM_INPUTS (gate3_sel_pkg::NUM_INPUTS)
    ) u_term_or (
        .i_sel  (sel),
        .i_data (i_cell_data),
        .o_gate (next_gate)
    );

    // Register the gate output
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= next_gate;
        end
    end

    // Output drives
    assign o_rdata = rdata;
    assign o_gate3 = gate_q;
    assign o_sel   = sel;

    // Term checks leave out cycles that sample ordinary reset, since the
    // gate register is forced low then; the disable alone is not enough,
    // because reset may be released on the very edge that samples it.
    // Checks, all in the system clock domain
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst || i_por);

    // Gate sampled in the cycle after the term is live
    sequence s_d_true;
        !i_srst && sel.g3_in4_true_en && i_cell_data.cell_data_in_d;
    endsequence

    sequence s_d_inv;
        !i_srst && sel.g3_in4_inv_en && !i_cell_data.cell_data_in_d;
    endsequence

    sequence s_c_true;
        !i_srst && sel.g3_in3_true_en && i_cell_data.cell_data_in_c;
    endsequence

    sequence s_c_inv;
        !i_srst && sel.g3_in3_inv_en && !i_cell_data.cell_data_in_c;
    endsequence

    AST_IN4_TRUE: assert property (s_d_true |=> o_gate3)
        else $error("Input d true term not seen on gate");

    AST_IN4_INV: assert property (s_d_inv |=> o_gate3)
        else $error("Input d inverted term not seen on gate");

    AST_IN3_TRUE: assert property (s_c_true |=> o_gate3)
        else $error("Input c true term not seen on gate");

    AST_IN3_INV: assert property (s_c_inv |=> o_gate3)
        else $error("Input c inverted term not seen on gate");

    AST_IN2_TRUE: assert property (
        (!i_srst && sel.g3_in2_true_en && i_cell_data.cell_data_in_b)
        ##1 1'b1
        |-> o_gate3)
        else $error("Input b true term not seen on gate");

    AST_IN2_INV: assert property (
        (!i_srst && sel.g3_in2_inv_en && !i_cell_data.cell_data_in_b)
        |=> $past(next_gate) && o_gate3)
        else $error("Input b inverted term not seen on gate");

    AST_IN1_TRUE: assert property (
        (!i_srst && sel.g3_in1_true_en && i_cell_data.cell_data_in_a)
        |=> o_gate3)
        else $error("Input a true term not seen on gate");

    AST_IN1_INV: assert property (
        (!i_srst && sel.g3_in1_inv_en && !i_cell_data.cell_data_in_a)
        |=> o_gate3)
        else $error("Input a inverted term not seen on gate");

    // Gate high only if some enabled term was true
    AST_EXCLUDE: assert property (
        !((sel[7] & i_cell_data[3]) | (sel[6] & ~i_cell_data[3]) |
          (sel[5] & i_cell_data[2]) | (sel[4] & ~i_cell_data[2]) |
          (sel[3] & i_cell_data[1]) | (sel[2] & ~i_cell_data[1]) |
          (sel[1] & i_cell_data[0]) | (sel[0] & ~i_cell_data[0]))
        |=> !o_gate3)
        else $error("Gate high with no enabled term true");

    // A write is read back by a following read
    sequence s_write_then_read;
        (i_wr && sel_hit) ##1 (i_rd && sel_hit && !i_wr && !i_srst);
    endsequence

    AST_READBACK: assert property (
        s_write_then_read |=> (o_rdata == $past(i_wdata, 2)))
        else $error("Selection readback differs from written value");

    // Ordinary reset leaves the selection untouched
    AST_SRST_KEEPS: assert property (
        @(posedge i_ref_clk) disable iff (i_por)
        (i_srst && !i_wr && !i_por) |=> $stable(sel))
        else $error("Selection changed by ordinary reset");

    // Unmapped read answers zero
    AST_UNMAPPED: assert property (
        (i_rd && !sel_hit) |=> (o_rdata == gate3_sel_pkg::UNMAPPED_VALUE))
        else $error("Unmapped read did not answer zero");

    // Read data stands one cycle, then falls back to zero
    AST_RDATA_IDLE: assert property (
        !i_rd |=> (o_rdata == gate3_sel_pkg::UNMAPPED_VALUE))
        else $error("Read data held past its cycle");

    // A mapped read hands back the setting of its own cycle
    sequence s_mapped_read;
        i_rd && sel_hit && !i_srst;
    endsequence

    AST_READ_ANSWER: assert property (
        s_mapped_read |=> (o_rdata == $past(sel)))
        else $error("Read data differs from stored setting");

    // A mapped write shows on the live setting one cycle later
    AST_WRITE_LANDS: assert property (
        (i_wr && sel_hit && !i_por) |=> (o_sel == $past(i_wdata)))
        else $error("Written value not on live setting");

    // A write to any other address leaves the setting alone
    AST_STRAY_WRITE: assert property (
        (i_wr && !sel_hit && !i_por) |=> $stable(sel))
        else $error("Setting changed by write elsewhere");

    // Power-on or brown-out loads the chosen pattern, even in reset
    AST_POR_LOADS: assert property (
        @(posedge i_ref_clk) disable iff (1'b0)
        i_por |=> (sel == gate3_sel_pkg::SEL_POR_VALUE))
        else $error("Power-on reset did not load the setting");

    // Ordinary reset clears the gate and the read answer
    AST_SRST_CLEARS: assert property (
        @(posedge i_ref_clk) disable iff (i_por)
        i_srst |=> (!o_gate3 && (o_rdata == gate3_sel_pkg::UNMAPPED_VALUE)))
        else $error("Ordinary reset left gate or read data set");

endmodule // gate3_input_stage

`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the gate-three input selection stage
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic       i_ref_clk = 1'h0; // System clock
    logic       i_srst    = 1'h1; // Ordinary reset
    logic       i_por     = 1'h1; // Power-on reset
    logic [7:0] i_addr    = 8'h00; // Register address
    logic [7:0] i_wdata   = 8'h00; // Write data
    logic       i_wr      = 1'h0; // Write strobe
    logic       i_rd      = 1'h0; // Read strobe
    logic [3:0] dat       = 4'h0; // Cell data lines
    logic [7:0] o_rdata;          // Read data
    logic       o_gate3;          // Gate output
    gate3_sel_pkg::gate3_input_select_t o_sel; // Live setting
    logic [7:0] rq[$];            // Expected read data
    logic [7:0] msel;             // Driver copy of the setting
    logic [7:0] gsel;             // Monitor copy of the setting
    logic       eg;               // Expected gate output
    logic       rp        = 1'h0; // Read answer due
    logic       gok       = 1'h0; // Monitor copy is known
    logic       in_rst    = 1'h1; // Driver holds ordinary reset
    int         n_errors  = 0;    // Mismatches
    int         checks    = 0;    // Comparisons
    int         seed      = 43009; // Random seed
    int         k;                // Loop and random word

    // Device under test
    gate3_input_stage uut (
        .i_ref_clk   (i_ref_clk),
        .i_srst      (i_srst),
        .i_por       (i_por),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .i_cell_data (gate3_sel_pkg::cell_data_t'(dat)),
        .o_rdata     (o_rdata),
        .o_gate3     (o_gate3),
        .o_sel       (o_sel)
    );

    // Free-running clock, 20 ns period
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // Expected gate: OR of enabled true and inverted terms
    function automatic logic gf(input logic [7:0] s, input logic [3:0] d);
        logic r;
        r = 1'h0;
        for (int i = 0; i < 4; i++) begin
            r = r | (s[2*i+1] & d[i]) | (s[2*i] & ~d[i]);
        end
        return r;
    endfunction

    // Compare read data
    task automatic chk_rd(input logic [7:0] e);
        checks++;
        if (o_rdata !== e) begin
            n_errors++;
            $display("FAIL %0t read %h exp %h", $time, o_rdata, e);
        end
    endtask

    // Compare gate output
    task automatic chk_g(input logic e);
        checks++;
        if (o_gate3 !== e) begin
            n_errors++;
            $display("FAIL %0t gate %b exp %b", $time, o_gate3, e);
        end
    endtask

    // One bus cycle plus new data lines; notes expected read data
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] x);
        @(posedge i_ref_clk);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
        dat     <= x;
        if (w && a == 8'h00) msel = d;
        if (r) rq.push_back((a == 8'h00 && !in_rst) ? msel : 8'h00);
    endtask

    // Counts and verdict, then stop
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Monitor between edges: compare, then note the next gate value
    always @(negedge i_ref_clk) begin
        if (gok) chk_g(eg);
        if (rp) chk_rd(rq.pop_front());
        eg = i_srst ? 1'h0 : gf(gsel, dat);
        if (i_por) gsel = 8'h00;
        else if (i_wr && i_addr == 8'h00) gsel = i_wdata;
        gok = gok | i_por;
        rp  = i_rd;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_srst <= 1'h0;
        i_por  <= 1'h0;
        in_rst = 1'h0;
        msel   = 8'h00;
        op(1'h0, 1'h1, 8'h00, 8'h00, 4'h0);
        // Each enable alone, then none, across all data values
        for (k = 0; k < 9; k++) begin
            op(1'h1, 1'h0, 8'h00, 8'(8'h01 << k), 4'h0);
            for (int d = 0; d < 16; d++) begin
                op(1'h0, 1'h1, 8'h00, 8'h00, d[3:0]);
            end
        end
        $display("test sweep done");
        // Random back-to-back traffic, some of it unmapped
        repeat (60) begin
            k = $random(seed);
            op(k[0], !k[0], k[1] ? 8'h00 : k[15:8], k[23:16], k[27:24]);
        end
        $display("test random done");
        // Ordinary reset keeps the setting and clears read data
        op(1'h1, 1'h0, 8'h00, 8'h5a, 4'h6);
        in_rst = 1'h1;
        op(1'h0, 1'h1, 8'h00, 8'h00, 4'h9);
        i_srst <= 1'h1;
        in_rst = 1'h0;
        op(1'h0, 1'h1, 8'h00, 8'h00, 4'h2);
        i_srst <= 1'h0;
        op(1'h0, 1'h0, 8'h00, 8'h00, 4'h2);
        repeat (3) @(posedge i_ref_clk);
        $display("test reset done");
        print_verdict();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        n_errors++;
        $display("FAIL %0t timeout", $time);
        print_verdict();
    end
endmodule // tb

`default_nettype wire
